// ### rtl/pdcs_dev_ctl_status.v
// device control and status register pair with apb access and interrupt
//
// Notes on behaviour
// - bit 0 enables correctable error reporting; resets to 0
// - bit 1 enables non-fatal error reporting; resets to 0
// - bit 2 enables fatal error reporting; resets to 0
// - bit 3 enables unsupported request reporting; resets to 0
// - bits 7:5 hold the payload limit, read-write, reset 000b
// - a payload write above the supported value stores the supported value
// - supported payload is 000b (128 bytes), so larger writes clamp to 000b
// - bit 10 aux power enable is sticky, resets 0, survives ordinary reset
// - bits 4, 8, 9, 11, 14:12 and 15 read zero, writes ignored
// - bit 16 set by correctable error, write one clears, resets 0
// - bit 17 set by non-fatal error, write one clears, resets 0
// - bit 18 set by fatal error, write one clears, resets 0
// - bit 19 set by unsupported request, write one clears, resets 0
// - errors are logged whatever the reporting enables say
// - bit 20 reads 1 while aux power is present; resets to 1
// - bit 21 and bits 31:22 read zero, writes ignored
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "pdcs_map.vh"

module pdcs_dev_ctl_status #(
  parameter [2:0] PAYLOAD_CAP = `PDCS_PAYLOAD_CAP
) (
  // clock and resets
  input  wire        clk,
  input  wire        nrst,
  input  wire        nPorRst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // error detection strobes: correctable, non-fatal, fatal, unsupported
  input  wire [3:0]  errDetect,
  input  wire        auxPowerPresent,
  // outputs to the rest of the device
  output reg  [3:0]  errReport,
  output reg  [2:0]  maxPayload,
  output reg         auxPowerEn,
  output wire        irq
);

  reg  [3:0]  errEnable;
  reg  [3:0]  errFlag;
  reg         auxDetected;
  reg  [4:0]  irqStatus;
  reg  [4:0]  irqMask;
  reg  [31:0] next_prdata;
  reg  [2:0]  next_payload;
  reg         addrHit;

  wire        setup    = psel & ~penable;
  wire        wrAccess = psel & penable & pwrite;
  wire        wrCtl    = wrAccess & (paddr == `PDCS_ADDR_CTLSTAT);
  wire        wrIrqSt  = wrAccess & (paddr == `PDCS_ADDR_IRQSTAT);
  wire        wrIrqMk  = wrAccess & (paddr == `PDCS_ADDR_IRQMASK);
  wire [2:0]  wrPayload = pwdata[`PDCS_PAYLOAD_MSB:`PDCS_PAYLOAD_LSB];
  wire [3:0]  errClear = (wrCtl & pstrb[2]) ?
                         pwdata[`PDCS_ERR_MSB:`PDCS_ERR_LSB] : 4'h0;
  // aux power arriving is an event too, so software can notice it
  reg         auxSeen;
  wire        auxRise  = auxPowerPresent & ~auxSeen;
  wire [4:0]  irqEvent = {auxRise, errDetect};
  wire [4:0]  irqClear = (wrIrqSt & pstrb[0]) ? pwdata[4:0] : 5'h00;

  // zero wait states: every transfer completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addrHit;
  assign irq     = |(irqStatus & irqMask);

  always @* begin
    addrHit = (paddr == `PDCS_ADDR_CTLSTAT) |
              (paddr == `PDCS_ADDR_IRQSTAT) |
              (paddr == `PDCS_ADDR_IRQMASK);
  end

  // a value larger than the capability is replaced, not truncated
  always @* begin
    if (wrPayload > PAYLOAD_CAP) begin
      next_payload = PAYLOAD_CAP;
    end else begin
      next_payload = wrPayload;
    end
  end

  // unimplemented and reserved bits stay zero in the read word
  always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `PDCS_ADDR_CTLSTAT: begin
        next_prdata[`PDCS_BIT_UREQ_EN:`PDCS_BIT_CORR_EN] = errEnable;
        next_prdata[`PDCS_PAYLOAD_MSB:`PDCS_PAYLOAD_LSB] = maxPayload;
        next_prdata[`PDCS_BIT_AUX_EN] = auxPowerEn;
        next_prdata[`PDCS_ERR_MSB:`PDCS_ERR_LSB] = errFlag;
        next_prdata[`PDCS_BIT_AUX_DET] = auxDetected;
      end
      `PDCS_ADDR_IRQSTAT: begin
        next_prdata[4:0] = irqStatus;
      end
      `PDCS_ADDR_IRQMASK: begin
        next_prdata[4:0] = irqMask;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // read data is captured in the setup cycle and held for the access
  always @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (setup & ~pwrite) begin
      prdata <= next_prdata;
    end
  end

  // control half of the word
  always @(posedge clk) begin
    if (!nrst) begin
      errEnable  <= `PDCS_RST_ENABLES;
      maxPayload <= `PDCS_RST_PAYLOAD;
    end else if (wrCtl & pstrb[0]) begin
      errEnable  <= pwdata[`PDCS_BIT_UREQ_EN:`PDCS_BIT_CORR_EN];
      maxPayload <= next_payload;
    end
  end

  // sticky bit only follows power-on reset, so an ordinary reset keeps it
  always @(posedge clk) begin
    if (!nPorRst) begin
      auxPowerEn <= `PDCS_RST_AUX_EN;
    end else if (wrCtl & pstrb[1]) begin
      auxPowerEn <= pwdata[`PDCS_BIT_AUX_EN];
    end
  end

  // error flags log regardless of enables; a new error beats its clear
  always @(posedge clk) begin
    if (!nrst) begin
      errFlag <= `PDCS_RST_ERR;
    end else begin
      errFlag <= (errFlag & ~errClear) | errDetect;
    end
  end

  // presence flag follows the input once out of reset
  always @(posedge clk) begin
    if (!nrst) begin
      auxDetected <= `PDCS_RST_AUX_DET;
      auxSeen     <= `PDCS_RST_AUX_DET;
    end else begin
      auxDetected <= auxPowerPresent;
      auxSeen     <= auxPowerPresent;
    end
  end

  // report requests are gated by the enables; logging above is not
  always @(posedge clk) begin
    if (!nrst) begin
      errReport <= 4'h0;
    end else begin
      errReport <= errDetect & errEnable;
    end
  end

  // interrupt status is sticky, write one clears, and an event wins
  always @(posedge clk) begin
    if (!nrst) begin
      irqStatus <= 5'h00;
      irqMask   <= `PDCS_RST_IRQMASK;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvent;
      if (wrIrqMk & pstrb[0]) begin
        irqMask <= pwdata[4:0];
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/pdcs_map.vh
// register map and field constants of the device control and status word
`ifndef PDCS_MAP_VH
`define PDCS_MAP_VH

`define PDCS_ADDR_W        12
`define PDCS_ADDR_CTLSTAT  12'h0E8
`define PDCS_ADDR_IRQSTAT  12'h100
`define PDCS_ADDR_IRQMASK  12'h104

`define PDCS_BIT_CORR_EN   0
`define PDCS_BIT_NFTL_EN   1
`define PDCS_BIT_FTL_EN    2
`define PDCS_BIT_UREQ_EN   3
`define PDCS_PAYLOAD_LSB   5
`define PDCS_PAYLOAD_MSB   7
`define PDCS_BIT_AUX_EN    10
`define PDCS_ERR_LSB       16
`define PDCS_ERR_MSB       19
`define PDCS_BIT_AUX_DET   20

`define PDCS_RST_ENABLES   4'h0
`define PDCS_RST_PAYLOAD   3'h0
`define PDCS_RST_AUX_EN    1'b0
`define PDCS_RST_ERR       4'h0
`define PDCS_RST_AUX_DET   1'b1
`define PDCS_RST_IRQMASK   5'h00
`define PDCS_PAYLOAD_CAP   3'h0

`endif

// ### testbench/pdcs_chk.sv
// port assertions for the device control and status block
`timescale 1ns/10ps
`default_nettype none
module pdcs_chk #(
  parameter [2:0] PAYLOAD_CAP = 3'h0
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        nPorRst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [3:0]  errDetect,
  input wire logic [3:0]  errReport,
  input wire logic [2:0]  maxPayload,
  input wire logic        auxPowerEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_report_cause: assert property (!(|(errReport & ~$past(errDetect))))
    else $error("report without detect");
  chk_payload_cap: assert property (maxPayload <= PAYLOAD_CAP)
    else $error("payload above cap");
  chk_rsvd_zero: assert property (prdata[31:21] == 0 &&
    prdata[15:11] == 0 && prdata[9:8] == 0)
    else $error("reserved bits set");
  chk_aux_hold: assert property (!$stable(auxPowerEn) |->
    $past(psel & penable & pwrite) | !$past(nPorRst))
    else $error("aux enable moved");
  chk_por_aux: assert property (!nPorRst |=> !auxPowerEn)
    else $error("aux enable kept");
  // an ordinary reset also clears the read data, so it may move then
  chk_rdata_hold: assert property (!$stable(prdata) |->
    $past(psel & !penable & !pwrite) || !$past(nrst))
    else $error("read data moved");
  chk_slverr_phase: assert property (pslverr |-> psel && penable)
    else $error("stray slave error");
  chk_ready_high: assert property (psel && penable |-> pready)
    else $error("wait state");
  cover property (|errReport);
  cover property (pslverr);
  cover property ($fell(auxPowerEn));
endmodule
`default_nettype wire

// ### testbench/pdcs_dev_ctl_status_tb.sv
// self-checking bench for the device control and status registers
`timescale 1ns/10ps
`default_nettype none
module pdcs_dev_ctl_status_tb;
  logic clk = 0, nrst = 0, nPorRst = 0, psel = 0, penable = 0, pwrite = 0;
  logic auxPowerPresent = 1, pready, pslverr, irq, auxPowerEn, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF, fire = 4'h0, errDetect, errReport;
  logic [2:0] maxPayload;
  int failCount = 0, nCompared = 0, cyc = 0;
  always #5 clk = ~clk;
  pdcs_err_src ES (.clk, .fire, .errDetect);
  pdcs_dev_ctl_status DUT (.clk, .nrst, .nPorRst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .errDetect,
    .auxPowerPresent, .errReport, .maxPayload, .auxPowerEn, .irq);
  task chk(input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      failCount++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // one-cycle reset: ordinary, or power-on when por is set
  task rst(input logic por);
    @(posedge clk);
    {nPorRst, nrst} <= {!por, por};
    @(posedge clk);
    {nPorRst, nrst} <= 2'b11;
  endtask
  task fireErr(input logic [3:0] m);
    @(posedge clk);
    fire <= m;
    @(posedge clk);
    fire <= 4'h0;
  endtask
  task tCtl;
    apb(0, 12'h0E8, 0); chk(32'h0010_0000, rd);
    apb(1, 12'h0E8, 32'hFFFF_FFFF);
    apb(0, 12'h0E8, 0); chk(32'h0010_040F, rd);
    chk(32'h0, {29'h0, maxPayload});
    chk(32'h1, {31'h0, auxPowerEn});
    rst(0);
    apb(0, 12'h0E8, 0); chk(32'h0010_0400, rd);
    rst(1);
    apb(0, 12'h0E8, 0); chk(32'h0010_0000, rd);
    $display("ctl test done");
  endtask
  task tErr;
    apb(1, 12'h0E8, 32'h0000_0405);
    fireErr(4'hF);
    @(posedge clk);
    #1 chk(32'h5, {28'h0, errReport});
    apb(0, 12'h0E8, 0); chk(32'h001F_0405, rd);
    apb(1, 12'h104, 32'h4);
    #1 chk(32'h1, {31'h0, irq});
    // clear lands on the same edge as a new correctable error
    fork
      apb(1, 12'h0E8, 32'h0005_0405);
      fireErr(4'h1);
    join
    apb(0, 12'h0E8, 0); chk(32'h001B_0405, rd);
    apb(1, 12'h100, 32'h1F);
    #1 chk(32'h0, {31'h0, irq});
    @(posedge clk);
    auxPowerPresent <= 0;
    apb(0, 12'h200, 0); chk(32'h1, {31'h0, err});
    apb(0, 12'h0E8, 0); chk(32'h000B_0405, rd);
    $display("err test done");
  endtask
  task tallyAndFinish;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failCount++;
      tallyAndFinish;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    {nPorRst, nrst} <= 2'b11;
    tCtl;
    tErr;
    tallyAndFinish;
  end
endmodule
bind pdcs_dev_ctl_status pdcs_chk #(.PAYLOAD_CAP(PAYLOAD_CAP)) CHK (.clk,
  .nrst, .nPorRst, .psel, .penable, .pwrite, .pready, .pslverr, .prdata,
  .errDetect, .errReport, .maxPayload, .auxPowerEn);
`default_nettype wire

// ### testbench/pdcs_err_src.sv
// error detector stand-in feeding one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module pdcs_err_src (
  input  wire logic       clk,
  input  wire logic [3:0] fire,
  output var  logic [3:0] errDetect = 4'h0
);
  // strobes, never held levels, as real detectors give
  always @(posedge clk) begin
    errDetect <= fire;
  end
endmodule
`default_nettype wire
